/* File: verilog/aec_axis_enable_control.sv */
module aec_axis_enable_control
   import aec_pkg::*;
(
   input  wire logic        core_clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        enable_req_i,
   input  wire logic [15:0] stop_style_select_i,
   input  wire logic        drive_iface_cfg_i,
   input  wire logic        drive_ready_i,
   input  wire logic        jerk_ctrl_en_i,
   input  wire logic [15:0] emerg_decel_i,
   input  wire logic [15:0] jerk_limit_i,
   input  wire logic [15:0] target_speed_i,
   input  wire logic        axis_fault_i,
   input  wire logic [15:0] axis_fault_code_i,
   input  wire logic        motion_task_req_i,
   input  wire logic        task_is_ack_i,
   input  wire logic        home_done_i,
   output logic             drive_power_en_o,
   output logic             status_o,
   output logic             axis_enabled_bit_o,
   output logic             axis_stopped_bit_o,
   output logic             busy_o,
   output logic             error_o,
   output logic [15:0]      fault_identifier_o,
   output logic [15:0]      fault_detail_code_o,
   output logic             homed_o,
   output logic             pulse_en_o,
   output logic [15:0]      speed_o,
   output logic             task_abort_o,
   output logic             task_accept_o,
   output logic             task_reject_o
);

   aec_state_t  state_q;
   aec_state_t  state_d;
   logic        ready_ok;
   logic [15:0] style_q;
   logic [15:0] rate_q;
   logic [15:0] speed_q;
   logic [15:0] speed_d;
   logic [15:0] decel_eff;
   logic [15:0] rate_use;
   logic [16:0] rate_sum;
   logic [15:0] brake_next;
   logic        style_ok;
   logic        jerk_mode;
   logic        drive_lost;
   logic        style_bad_ev;
   logic        disable_ev;
   logic        status_q;
   logic        enabled_bit_q;
   logic        stopped_q;
   logic        busy_q;
   logic        power_q;
   logic        error_q;
   logic [15:0] fid_q;
   logic [15:0] fdc_q;
   logic        homed_q;
   logic        pulse_q;
   logic        abort_q;
   logic        accept_q;
   logic        reject_q;

   function automatic logic style_valid(input logic [15:0] s);
      style_valid = (s == STOP_EMERG) || (s == STOP_IMMED) || (s == STOP_JERK);
   endfunction
   function automatic logic fault_ack_ok();
      fault_ack_ok = motion_task_req_i && task_is_ack_i && !axis_fault_i;
   endfunction

   aec_pin_filter u_ready (
      .core_clk_i (core_clk_i),
      .reset_n_i  (reset_n_i),
      .pin_i      (drive_ready_i),
      .level_o    (ready_ok)
   );
   assign style_ok     = style_valid(stop_style_select_i);
   assign drive_lost   = (state_q == ST_ON) && drive_iface_cfg_i && !ready_ok;
   assign style_bad_ev = enable_req_i && !style_ok && (state_q == ST_OFF);
   assign disable_ev   = (state_q == ST_ON) && !enable_req_i;
   // Zero deceleration would never reach standstill
   assign decel_eff    = (emerg_decel_i == SPEED_RST) ? RATE_MIN : emerg_decel_i;
   assign jerk_mode    = (style_q == STOP_JERK) && jerk_ctrl_en_i;
   assign rate_use     = jerk_mode ? rate_q : decel_eff;
   assign rate_sum     = {1'b0, rate_q} + {1'b0, jerk_limit_i};
   assign brake_next   = (speed_q > rate_use) ? speed_q - rate_use : SPEED_RST;
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_OFF: begin
            if (enable_req_i && style_ok && !error_q) begin
               state_d = drive_iface_cfg_i ? ST_WAIT_READY : ST_ON;
            end
         end
         ST_WAIT_READY: begin
            if (axis_fault_i) begin
               state_d = ST_FAULT;
            end else if (!enable_req_i) begin
               state_d = ST_OFF;
            end else if (ready_ok) begin
               state_d = ST_ON;
            end
         end
         ST_ON: begin
            if (axis_fault_i || drive_lost) begin
               state_d = ST_FAULT;
            end else if (!enable_req_i) begin
               state_d = (stop_style_select_i == STOP_IMMED) ? ST_OFF : ST_BRAKE;
            end
         end
         ST_BRAKE: begin
            if (axis_fault_i) begin
               state_d = ST_FAULT;
            end else if (speed_q == SPEED_RST) begin
               state_d = ST_OFF;
            end
         end
         ST_FAULT: begin
            // Back to idle; idle re-enables while the request is still high
            if (fault_ack_ok()) begin
               state_d = ST_OFF;
            end
         end
      endcase
   end

   always_comb begin
      speed_d = SPEED_RST;
      if (state_d == ST_ON) begin
         speed_d = target_speed_i;
      end else if (state_d == ST_BRAKE) begin
         speed_d = (state_q == ST_BRAKE) ? brake_next : speed_q;
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_q <= ST_OFF;
      end else begin
         state_q <= state_d;
      end
   end
   // Style latched at the start of a disable, invalid codes brake as style 0
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         style_q <= STOP_EMERG;
      end else if (disable_ev) begin
         style_q <= style_ok ? stop_style_select_i : STOP_EMERG;
      end
   end
   // Jerk ramp: deceleration grows by the jerk each cycle up to its limit
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rate_q <= RATE_MIN;
      end else if (state_q != ST_BRAKE) begin
         rate_q <= (jerk_limit_i == SPEED_RST || jerk_limit_i > decel_eff) ? decel_eff : jerk_limit_i;
      end else if (rate_sum >= {1'b0, decel_eff}) begin
         rate_q <= decel_eff;
      end else begin
         rate_q <= rate_sum[15:0];
      end
   end
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         speed_q   <= SPEED_RST;
         stopped_q <= 1'b1;
         pulse_q   <= 1'b0;
      end else begin
         speed_q   <= speed_d;
         stopped_q <= (speed_d == SPEED_RST);
         pulse_q   <= (speed_d != SPEED_RST);
      end
   end
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         status_q      <= 1'b0;
         enabled_bit_q <= 1'b0;
         power_q       <= 1'b0;
         busy_q        <= 1'b0;
      end else begin
         status_q      <= (state_d == ST_ON) || (state_d == ST_BRAKE);
         enabled_bit_q <= (state_d == ST_ON) || (state_d == ST_BRAKE);
         power_q       <= (state_d != ST_OFF) && (state_d != ST_FAULT);
         busy_q        <= enable_req_i || (state_d != ST_OFF);
      end
   end
   // New fault wins over an acknowledge in the same cycle
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         error_q <= 1'b0;
         fid_q   <= FID_NONE;
         fdc_q   <= FDC_NONE;
      end else if (axis_fault_i) begin
         error_q <= 1'b1;
         fid_q   <= FID_AXIS;
         fdc_q   <= axis_fault_code_i;
      end else if (drive_lost) begin
         error_q <= 1'b1;
         fid_q   <= FID_DRIVE_LOST;
         fdc_q   <= FDC_READY_DROP;
      end else if (style_bad_ev) begin
         error_q <= 1'b1;
         fid_q   <= FID_STOP_STYLE;
         fdc_q   <= stop_style_select_i;
      end else if (fault_ack_ok()) begin
         error_q <= 1'b0;
         fid_q   <= FID_NONE;
         fdc_q   <= FDC_NONE;
      end
   end
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         homed_q <= 1'b0;
      end else if (state_d != ST_ON && state_d != ST_BRAKE) begin
         homed_q <= 1'b0;
      end else if (home_done_i) begin
         homed_q <= 1'b1;
      end
   end
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         abort_q  <= 1'b0;
         accept_q <= 1'b0;
         reject_q <= 1'b0;
      end else begin
         abort_q  <= disable_ev || ((state_q == ST_ON || state_q == ST_BRAKE) && state_d == ST_FAULT);
         // Braking axis takes no new motion either
         accept_q <= motion_task_req_i && (task_is_ack_i || state_q == ST_ON);
         reject_q <= motion_task_req_i && !task_is_ack_i && state_q != ST_ON;
      end
   end

   assign drive_power_en_o    = power_q;
   assign status_o            = status_q;
   assign axis_enabled_bit_o  = enabled_bit_q;
   assign axis_stopped_bit_o  = stopped_q;
   assign busy_o              = busy_q;
   assign error_o             = error_q;
   assign fault_identifier_o  = fid_q;
   assign fault_detail_code_o = fdc_q;
   assign homed_o             = homed_q;
   assign pulse_en_o          = pulse_q;
   assign speed_o             = speed_q;
   assign task_abort_o        = abort_q;
   assign task_accept_o       = accept_q;
   assign task_reject_o       = reject_q;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);

   sequence s_disable_start;
      state_q == ST_ON && !enable_req_i && !axis_fault_i && !drive_lost;
   endsequence
   sequence s_fault_acked;
      state_q == ST_FAULT && fault_ack_ok() && enable_req_i;
   endsequence

   property p_abort;
      s_disable_start |=> task_abort_o;
   endproperty
   a_abort: assert property (p_abort) else $error("Disable did not abort tasks");
   property p_emerg_brake;
      s_disable_start ##0 (stop_style_select_i == STOP_EMERG) |=> state_q == ST_BRAKE && status_o;
   endproperty
   a_emerg_brake: assert property (p_emerg_brake) else $error("Style 0 did not brake");
   property p_immed;
      s_disable_start ##0 (stop_style_select_i == STOP_IMMED) |=> !status_o && !pulse_en_o && speed_o == 16'h0000;
   endproperty
   a_immed: assert property (p_immed) else $error("Style 1 did not cut at once");
   property p_jerk_limit;
      (state_q == ST_BRAKE && $past(state_q) == ST_BRAKE && !axis_fault_i)
         |-> ($past(speed_o) - speed_o) <= decel_eff;
   endproperty
   a_jerk_limit: assert property (p_jerk_limit) else $error("Braking exceeded deceleration");
   property p_no_task;
      task_accept_o && !$past(task_is_ack_i) |-> $past(state_q) == ST_ON;
   endproperty
   a_no_task: assert property (p_no_task) else $error("Task accepted while disabled");
   property p_not_homed;
      !status_o |-> !homed_o;
   endproperty
   a_not_homed: assert property (p_not_homed) else $error("Homed while disabled");
   property p_hold_status;
      (state_q == ST_BRAKE && speed_o != 16'h0000 && !axis_fault_i) |=> status_o;
   endproperty
   a_hold_status: assert property (p_hold_status) else $error("Status fell before standstill");
   property p_ready_first;
      $rose(status_o) && drive_iface_cfg_i |-> $past(ready_ok);
   endproperty
   a_ready_first: assert property (p_ready_first) else $error("Status rose without drive ready");
   property p_busy;
      enable_req_i |=> busy_o;
   endproperty
   a_busy: assert property (p_busy) else $error("Busy low while requested");
   property p_error;
      axis_fault_i |=> error_o && fault_identifier_o == FID_AXIS && fault_detail_code_o == $past(axis_fault_code_i);
   endproperty
   a_error: assert property (p_error) else $error("Axis fault not reported");
   property p_power;
      state_q == ST_OFF && enable_req_i && style_ok && !error_q && drive_iface_cfg_i |=> drive_power_en_o && !status_o;
   endproperty
   a_power: assert property (p_power) else $error("Drive power not raised");
   property p_enabled_bit;
      status_o == axis_enabled_bit_o;
   endproperty
   a_enabled_bit: assert property (p_enabled_bit) else $error("Enabled bit differs from status");
   property p_standstill;
      axis_stopped_bit_o == (speed_o == 16'h0000);
   endproperty
   a_standstill: assert property (p_standstill) else $error("Standstill bit wrong");
   property p_reenable;
      s_fault_acked ##1 (enable_req_i && style_ok && !drive_iface_cfg_i && !axis_fault_i) |=> status_o;
   endproperty
   a_reenable: assert property (p_reenable) else $error("No re-enable after acknowledge");
endmodule // aec_axis_enable_control

/* File: shared/aec_pkg.sv */
package aec_pkg;

   localparam int unsigned WORD_W = 16;

   // Stop style codes
   localparam logic [15:0] STOP_EMERG = 16'h0000;
   localparam logic [15:0] STOP_IMMED = 16'h0001;
   localparam logic [15:0] STOP_JERK  = 16'h0002;

   // Fault identifiers and detail codes
   localparam logic [15:0] FID_NONE       = 16'h0000;
   localparam logic [15:0] FID_AXIS       = 16'h8001;
   localparam logic [15:0] FID_STOP_STYLE = 16'h8002;
   localparam logic [15:0] FID_DRIVE_LOST = 16'h8003;
   localparam logic [15:0] FDC_NONE       = 16'h0000;
   localparam logic [15:0] FDC_READY_DROP = 16'h0001;

   // Reset values
   localparam logic [15:0] SPEED_RST = 16'h0000;
   localparam logic [15:0] RATE_MIN  = 16'h0001;

   typedef enum logic [2:0] {
      ST_OFF,
      ST_WAIT_READY,
      ST_ON,
      ST_BRAKE,
      ST_FAULT
   } aec_state_t;

endpackage

/* File: verilog/aec_pin_filter.sv */
module aec_pin_filter (
   input  wire logic core_clk_i,
   input  wire logic reset_n_i,
   input  wire logic pin_i,
   output logic      level_o
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic level_q;

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Change accepted only once two stages agree
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         level_q <= 1'b0;
      end else if (s2_q == s3_q) begin
         level_q <= s3_q;
      end
   end

   assign level_o = level_q;
endmodule // aec_pin_filter

/* File: sim/aec_drive_model.sv */
module aec_drive_model #(
   parameter int unsigned READY_DLY = 5
) (
   input  wire logic core_clk_i,
   input  wire logic reset_n_i,
   input  wire logic power_en_i,
   input  wire logic drop_i,
   output logic      ready_o
);
   timeunit 1ns;
   timeprecision 100ps;

   int unsigned cnt_q;

   // Ready only after power has settled; a commanded drop models a tripped drive
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_q   <= 0;
         ready_o <= 1'b0;
      end else if (!power_en_i || drop_i) begin
         cnt_q   <= 0;
         ready_o <= 1'b0;
      end else if (cnt_q < READY_DLY) begin
         cnt_q   <= cnt_q + 1;
      end else begin
         ready_o <= 1'b1;
      end
   end
endmodule // aec_drive_model

/* File: sim/aec_axis_enable_control_tb_top.sv */
module aec_axis_enable_control_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import aec_pkg::*;

   logic        core_clk_i = 1'b0;
   logic        reset_n_i  = 1'b0;
   logic        en = 1'b0, iface = 1'b0, jerk = 1'b0, fault = 1'b0;
   logic        treq = 1'b0, tack = 1'b0, home = 1'b0, drop = 1'b0;
   logic [15:0] style = STOP_IMMED, fcode = 16'h0000;
   logic [15:0] decel = 16'h0004, jlim = 16'h0001, tgt = 16'h000a;
   logic        ready, power, status, enbit, stopped, busy, err, homed, pulse, abort, acc, rej;
   logic [15:0] fid, fdc, speed, expv;
   int          bad_count = 0, tests_run = 0, cycles = 0;

   aec_axis_enable_control u_dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .enable_req_i(en),
      .stop_style_select_i(style), .drive_iface_cfg_i(iface), .drive_ready_i(ready), .jerk_ctrl_en_i(jerk),
      .emerg_decel_i(decel), .jerk_limit_i(jlim), .target_speed_i(tgt), .axis_fault_i(fault),
      .axis_fault_code_i(fcode), .motion_task_req_i(treq), .task_is_ack_i(tack), .home_done_i(home),
      .drive_power_en_o(power), .status_o(status), .axis_enabled_bit_o(enbit), .axis_stopped_bit_o(stopped),
      .busy_o(busy), .error_o(err), .fault_identifier_o(fid), .fault_detail_code_o(fdc), .homed_o(homed),
      .pulse_en_o(pulse), .speed_o(speed), .task_abort_o(abort), .task_accept_o(acc), .task_reject_o(rej));

   aec_drive_model u_drive (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .power_en_i(power),
      .drop_i(drop), .ready_o(ready));

   initial begin
      forever #12.5 core_clk_i = ~core_clk_i;
   end

   task summarize();
      $display("Checks run %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Hang guard well above the hundred or so cycles the tests need
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         $display("[ERR] run_time expected finished seen hang");
         summarize();
      end
   end

   task step();
      @(posedge core_clk_i);
   endtask

   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wt(ref logic s, input logic v, input int mx, input string nm);
      int i;
      i = 0;
      while (s !== v && i < mx) begin
         step();
         #1;
         i++;
      end
      chk(nm, 16'(v), 16'(s));
   endtask

   // One task request; answer is a single-cycle pulse
   task req(input logic a, input logic ea);
      int i;
      step();
      treq <= 1'b1;
      tack <= a;
      step();
      treq <= 1'b0;
      tack <= 1'b0;
      #1;
      i = 0;
      while (!(acc === 1'b1 || rej === 1'b1) && i < 3) begin
         step();
         #1;
         i++;
      end
      chk("task_accept", 16'(ea), 16'(acc));
      chk("task_reject", 16'(!ea), 16'(rej));
   endtask

   task enable_on(input int mx);
      step();
      en <= 1'b1;
      #1;
      wt(status, 1'b1, mx, "status_on");
   endtask

   task disable_start();
      step();
      en <= 1'b0;
      #1;
      wt(abort, 1'b1, 3, "task_abort");
   endtask

   initial begin
      repeat (4) step();
      reset_n_i <= 1'b1;
      repeat (3) step();

      enable_on(3);
      chk("enabled_bit", 1, enbit);
      chk("busy_on", 1, busy);
      step();
      #1;
      chk("speed_on", tgt, speed);
      disable_start();
      chk("status_immed", 0, status);
      chk("speed_immed", 0, speed);
      chk("pulse_immed", 0, pulse);
      step();
      #1;
      chk("busy_off", 0, busy);
      $display("Test immediate stop done");

      style <= STOP_EMERG;
      enable_on(4);
      disable_start();
      expv = tgt;
      while (expv != 0) begin
         chk("brake_speed", expv, speed);
         chk("status_brake", 1, status);
         step();
         #1;
         expv = (expv > decel) ? expv - decel : 16'h0000;
      end
      chk("brake_speed", 0, speed);
      chk("stopped_bit", 1, stopped);
      chk("status_standstill", 1, status);
      step();
      #1;
      chk("status_emerg_off", 0, status);
      chk("enabled_bit_off", 0, enbit);
      $display("Test emergency ramp done");

      style <= STOP_JERK;
      jerk  <= 1'b1;
      enable_on(4);
      disable_start();
      chk("jerk_first", tgt, speed);
      step();
      #1;
      chk("jerk_step", tgt - jlim, speed);
      wt(stopped, 1'b1, 8, "jerk_stopped");
      chk("status_jerk_hold", 1, status);
      step();
      #1;
      chk("status_jerk_off", 0, status);
      jerk <= 1'b0;
      $display("Test jerk ramp done");

      style <= STOP_IMMED;
      req(1'b0, 1'b0);
      req(1'b1, 1'b1);
      enable_on(4);
      req(1'b0, 1'b1);
      step();
      home <= 1'b1;
      step();
      home <= 1'b0;
      #1;
      wt(homed, 1'b1, 3, "homed_on");
      disable_start();
      wt(homed, 1'b0, 3, "homed_off");
      $display("Test tasks and homing done");

      enable_on(4);
      step();
      fault <= 1'b1;
      fcode <= 16'h00a5;
      #1;
      wt(err, 1'b1, 3, "error_axis");
      chk("fault_id_axis", FID_AXIS, fid);
      chk("fault_detail_axis", 16'h00a5, fdc);
      wt(status, 1'b0, 2, "status_fault");
      req(1'b0, 1'b0);
      step();
      fault <= 1'b0;
      req(1'b1, 1'b1);
      wt(err, 1'b0, 3, "error_clear");
      wt(status, 1'b1, 4, "auto_reenable");
      disable_start();
      $display("Test fault recovery done");

      style <= STOP_EMERG;
      enable_on(4);
      step();
      tgt <= 16'h0000;
      #1;
      wt(stopped, 1'b1, 3, "stopped_before_off");
      disable_start();
      step();
      #1;
      chk("busy_done", 0, busy);
      chk("status_done", 0, status);
      chk("enabled_bit_done", 0, enbit);
      tgt   <= 16'h000a;
      style <= 16'h0007;
      $display("Test orderly disable done");

      step();
      en <= 1'b1;
      #1;
      wt(err, 1'b1, 3, "error_style");
      chk("fault_id_style", FID_STOP_STYLE, fid);
      chk("fault_detail_style", 16'h0007, fdc);
      chk("status_style", 0, status);
      step();
      en    <= 1'b0;
      style <= STOP_IMMED;
      req(1'b1, 1'b1);
      wt(err, 1'b0, 3, "error_clear_style");
      $display("Test invalid stop style done");

      step();
      iface <= 1'b1;
      en    <= 1'b1;
      #1;
      wt(power, 1'b1, 3, "power_en");
      chk("status_wait", 0, status);
      wt(status, 1'b1, 14, "status_ready");
      chk("ready_seen", 1, ready);
      step();
      drop <= 1'b1;
      #1;
      wt(err, 1'b1, 8, "error_drop");
      chk("fault_id_drop", FID_DRIVE_LOST, fid);
      chk("fault_detail_drop", FDC_READY_DROP, fdc);
      step();
      en   <= 1'b0;
      drop <= 1'b0;
      req(1'b1, 1'b1);
      wt(err, 1'b0, 3, "error_clear_drop");
      $display("Test drive interface done");

      summarize();
   end
endmodule // aec_axis_enable_control_tb_top
